// File: logic/wdtsm_pkg.sv
// Constants and register layout for the sleep-aware watchdog timer
package wdtsm_pkg;
  // Clock and time base
  localparam int unsigned CLK_SYS_HZ = 50_000_000;
  localparam int unsigned LF_OSC_HZ = 31_000;
  localparam int unsigned LF_DIV_CYCLES = CLK_SYS_HZ / LF_OSC_HZ;
  localparam int LF_DIV_W = 11;
  localparam logic [LF_DIV_W-1:0] LF_DIV_LAST = LF_DIV_W'(LF_DIV_CYCLES - 1);
  localparam int CNT_W = 23;
  localparam int unsigned BASE_SHIFT = 5;

  // Register bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_POWER_CONTROL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h3;

  // watchdog_control fields
  localparam int SWEN_BIT = 0;
  localparam int PERIOD_LSB = 1;
  localparam int PERIOD_MSB = 5;
  localparam logic [4:0] PERIOD_RESET = 5'h0b;
  localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
  localparam logic SWEN_RESET = 1'b0;

  // power_control_reg fields
  localparam int TO_BIT = 0;
  localparam int PD_BIT = 1;
  localparam int WATCHDOG_RESET_FLAG_BIT = 2;

  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_RESET_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;

  // wdt_mode_config encodings
  typedef enum logic [1:0] {
    WDTSM_MODE_OFF = 2'b00,
    WDTSM_MODE_SW = 2'b01,
    WDTSM_MODE_AWAKE = 2'b10,
    WDTSM_MODE_ON = 2'b11
  } wdtsm_mode_e;
endpackage : wdtsm_pkg

// File: logic/wdtsm_top.sv
// Watchdog timer with sleep handling, register port and interrupt
// Contract
// - Awake time-out without a clear request forces a system reset.
// - Counter advances on a 31 kHz tick; 1 ms is the base unit.
// - Mode 00 keeps the watchdog off regardless of enable bit or sleep.
// - Mode 11 is always active, also during sleep.
// - Mode 10 counts awake only, off during sleep.
// - Mode 01 follows the software enable bit; sleep has no effect.
// - Period selectable 1 ms to 256 s; two seconds after reset.
// - Counter cleared on reset, clear, sleep, wake, osc fail, disable, start-up.
// - Sleep entry clears then resumes if enabled; sleep exit clears again.
// - Crystal clock wake holds counter clear until start-up timer ends.
// - Internal oscillator divider changes leave the counter alone.
// - Sleep time-out wakes the device and updates time-out and power-down flags.
// - A watchdog reset is recorded in a reset-cause flag.
// - Period codes 0 to 18 map to ratios 1:32 doubling to 1:8388608.
// - Codes 19 to 31 act as the minimum ratio 1:32.
// - Enable at bit 0, period at bits 5..1, bits 7..6 read zero.
`timescale 1ns/1ps
module wdtsm_top
  import wdtsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] wdt_mode_config,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_enter,
  input wire logic sleep_exit,
  input wire logic osc_fail,
  input wire logic osc_startup_timer,
  input wire logic sys_clk_is_crystal,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic wdt_reset_req,
  output logic wake_req,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_reset_flag,
  output logic irq
);

  logic [1:0] mode_q;
  logic mode_valid_q;
  logic soft_watchdog_enable_q;
  logic [4:0] period_select_field_q;
  logic sleep_q;
  logic hold_q;
  logic ost_prev_q;
  logic [LF_DIV_W-1:0] lf_div_q;
  logic lf_tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  logic active;
  logic cnt_clear;
  logic timeout;
  logic wake_exit;
  logic to_flag_n_q;
  logic pd_flag_n_q;
  logic watchdog_reset_flag_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] rdata_q;
  logic reset_pulse_q;
  logic wake_pulse_q;
  logic irq_q;
  logic wr_ctrl;
  logic wr_pwr;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl = reg_we && (reg_addr == ADDR_WATCHDOG_CONTROL);
  assign wr_pwr = reg_we && (reg_addr == ADDR_POWER_CONTROL);
  assign wr_stat = reg_we && (reg_addr == ADDR_IRQ_STATUS);
  assign wr_mask = reg_we && (reg_addr == ADDR_IRQ_MASK);

  // Mode strap is caught once after reset release, never under the async reset
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 2'h0;
      mode_valid_q <= 1'b0;
    end
    else if (!mode_valid_q)
    begin
      mode_q <= wdt_mode_config;
      mode_valid_q <= 1'b1;
    end
  end

  // Control register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      soft_watchdog_enable_q <= SWEN_RESET;
      period_select_field_q <= PERIOD_RESET;
    end
    else if (wr_ctrl)
    begin
      soft_watchdog_enable_q <= reg_wdata[SWEN_BIT];
      period_select_field_q <= reg_wdata[PERIOD_MSB:PERIOD_LSB];
    end
  end

  // Low-frequency time base; the 31 kHz oscillator is modelled as an enable
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      lf_div_q <= '0;
    else if (lf_div_q == LF_DIV_LAST)
      lf_div_q <= '0;
    else
      lf_div_q <= lf_div_q + 1'b1;
  end
  assign lf_tick = (lf_div_q == LF_DIV_LAST);

  // Mode decode
  always_comb
  begin
    case (wdtsm_mode_e'(mode_q))
      WDTSM_MODE_ON: active = mode_valid_q;
      WDTSM_MODE_AWAKE: active = mode_valid_q && !sleep_q;
      WDTSM_MODE_SW: active = mode_valid_q && soft_watchdog_enable_q;
      WDTSM_MODE_OFF: active = 1'b0;
      default: active = 1'b0;
    endcase
  end

  // Period decode; reserved codes fall back to the shortest interval
  always_comb
  begin
    if (period_select_field_q <= PERIOD_MAX_CODE)
      limit = CNT_W'((24'h1 << (period_select_field_q + 5'(BASE_SHIFT))) - 24'h1);
    else
      limit = CNT_W'((24'h1 << BASE_SHIFT) - 24'h1);
  end

  // Sleep state; a watchdog wake ends sleep as well as the core's own exit
  // Registered wake pulse keeps the time-out path free of a combinational loop
  assign wake_exit = sleep_q && (sleep_exit || wake_pulse_q);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      sleep_q <= 1'b0;
    else if (sleep_enter)
      sleep_q <= 1'b1;
    else if (wake_exit)
      sleep_q <= 1'b0;
  end

  // Crystal wake holds the counter until the start-up timer drops
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      hold_q <= 1'b0;
      ost_prev_q <= 1'b0;
    end
    else
    begin
      ost_prev_q <= osc_startup_timer;
      if (wake_exit && sys_clk_is_crystal)
        hold_q <= 1'b1;
      else if (ost_prev_q && !osc_startup_timer)
        hold_q <= 1'b0;
    end
  end

  // Divider selection of the internal oscillator is no input here, so it cannot clear
  assign cnt_clear = !active || watchdog_clear_instr || sleep_enter || wake_exit
                     || osc_fail || osc_startup_timer || hold_q;
  assign timeout = lf_tick && !cnt_clear && (cnt_q == limit);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cnt_q <= '0;
    else if (cnt_clear || timeout)
      cnt_q <= '0;
    else if (lf_tick)
      cnt_q <= cnt_q + 1'b1;
  end

  // Event outputs: reset when awake, wake when asleep
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reset_pulse_q <= 1'b0;
      wake_pulse_q <= 1'b0;
    end
    else
    begin
      reset_pulse_q <= timeout && !sleep_q;
      wake_pulse_q <= timeout && sleep_q;
    end
  end

  // Status flags; hardware events win over software writes
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b1;
    end
    else if (timeout)
    begin
      to_flag_n_q <= 1'b0;
      pd_flag_n_q <= !sleep_q;
    end
    else if (sleep_enter)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b0;
    end
    else if (watchdog_clear_instr)
    begin
      to_flag_n_q <= 1'b1;
      pd_flag_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      watchdog_reset_flag_q <= 1'b0;
    else if (timeout && !sleep_q)
      watchdog_reset_flag_q <= 1'b1;
    else if (wr_pwr && reg_wdata[WATCHDOG_RESET_FLAG_BIT])
      watchdog_reset_flag_q <= 1'b0;
  end

  // Interrupt status, write one to clear, set wins
  assign irq_set[IRQ_RESET_BIT] = timeout && !sleep_q;
  assign irq_set[IRQ_WAKE_BIT] = timeout && sleep_q;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      irq_stat_q <= '0;
    else
      irq_stat_q <= irq_set | (irq_stat_q & ~({IRQ_W{wr_stat}} & reg_wdata[IRQ_W-1:0]));
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      irq_mask_q <= '0;
    else if (wr_mask)
      irq_mask_q <= reg_wdata[IRQ_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= |(irq_set | (irq_stat_q & ~({IRQ_W{wr_stat}} & reg_wdata[IRQ_W-1:0]))
                 & (wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_q));
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (reg_re)
    begin
      case (reg_addr)
        ADDR_WATCHDOG_CONTROL:
          rdata_q <= {2'h0, period_select_field_q, soft_watchdog_enable_q};
        ADDR_POWER_CONTROL: rdata_q <= {5'h00, watchdog_reset_flag_q, pd_flag_n_q, to_flag_n_q};
        ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_stat_q};
        ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;
  assign wdt_reset_req = reset_pulse_q;
  assign wake_req = wake_pulse_q;
  assign timeout_flag_n = to_flag_n_q;
  assign powerdown_flag_n = pd_flag_n_q;
  assign watchdog_reset_flag = watchdog_reset_flag_q;
  assign irq = irq_q;

  // Checks
  sequence s_awake_timeout;
    timeout && !sleep_q;
  endsequence
  sequence s_sleep_timeout;
    timeout && sleep_q;
  endsequence

  property p_reset_on_awake_timeout;
    @(posedge clk_sys) disable iff (reset) s_awake_timeout |=> wdt_reset_req && !wake_req;
  endproperty
  a_reset_on_awake_timeout: assert property (p_reset_on_awake_timeout)
    else $error("awake time-out gave no reset");

  property p_sleep_timeout_wakes;
    @(posedge clk_sys) disable iff (reset)
      s_sleep_timeout |=> wake_req && !wdt_reset_req && !timeout_flag_n && !powerdown_flag_n;
  endproperty
  a_sleep_timeout_wakes: assert property (p_sleep_timeout_wakes)
    else $error("sleep time-out did not wake with flags");

  property p_mode_off_idle;
    @(posedge clk_sys) disable iff (reset) (mode_q == 2'b00) |-> cnt_q == '0 && !timeout;
  endproperty
  a_mode_off_idle: assert property (p_mode_off_idle)
    else $error("watchdog counted in mode off");

  property p_mode_on_sleep;
    @(posedge clk_sys) disable iff (reset) (mode_q == 2'b11 && mode_valid_q) |-> active;
  endproperty
  a_mode_on_sleep: assert property (p_mode_on_sleep)
    else $error("always-on mode inactive");

  property p_awake_mode_sleep;
    @(posedge clk_sys) disable iff (reset) (mode_q == 2'b10 && sleep_q) |-> !active;
  endproperty
  a_awake_mode_sleep: assert property (p_awake_mode_sleep)
    else $error("awake-only mode active in sleep");

  property p_sw_mode;
    @(posedge clk_sys) disable iff (reset)
      (mode_q == 2'b01 && mode_valid_q) |-> active == soft_watchdog_enable_q;
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("software mode ignores enable bit");

  property p_clear_instr;
    @(posedge clk_sys) disable iff (reset) watchdog_clear_instr |=> cnt_q == '0;
  endproperty
  a_clear_instr: assert property (p_clear_instr)
    else $error("clear did not zero counter");

  property p_crystal_hold;
    @(posedge clk_sys) disable iff (reset) hold_q |=> cnt_q == '0;
  endproperty
  a_crystal_hold: assert property (p_crystal_hold)
    else $error("counter moved during start-up hold");

  property p_reserved_period;
    @(posedge clk_sys) disable iff (reset) period_select_field_q > 5'h12 |-> limit == 23'd31;
  endproperty
  a_reserved_period: assert property (p_reserved_period)
    else $error("reserved period not minimum");

  property p_single_pulse;
    @(posedge clk_sys) disable iff (reset) wdt_reset_req |=> !wdt_reset_req;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("reset request longer than one cycle");

  property p_watchdog_reset_flag_set;
    @(posedge clk_sys) disable iff (reset) s_awake_timeout |=> watchdog_reset_flag;
  endproperty
  a_watchdog_reset_flag_set: assert property (p_watchdog_reset_flag_set)
    else $error("reset cause flag not set");

endmodule : wdtsm_top

// File: test/wdtsm_core_model.sv
// Core-side model issuing clear and sleep requests toward the watchdog
`timescale 1ns/1ps
module wdtsm_core_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear_cmd,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  input wire logic wake_req,
  output logic watchdog_clear_instr,
  output logic sleep_enter,
  output logic sleep_exit,
  output logic asleep_q
);
  logic [2:0] cmd_q;
  // Commands become one-cycle pulses on their rising edge; exit only while asleep
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cmd_q <= 3'h0;
      watchdog_clear_instr <= 1'b0;
      sleep_enter <= 1'b0;
      sleep_exit <= 1'b0;
      asleep_q <= 1'b0;
    end
    else
    begin
      cmd_q <= {wake_cmd, sleep_cmd, clear_cmd};
      watchdog_clear_instr <= clear_cmd & ~cmd_q[0];
      sleep_enter <= sleep_cmd & ~cmd_q[1] & ~asleep_q;
      sleep_exit <= wake_cmd & ~cmd_q[2] & asleep_q;
      if (sleep_enter)
        asleep_q <= 1'b1;
      else if (sleep_exit | wake_req)
        asleep_q <= 1'b0;
    end
  end
endmodule : wdtsm_core_model

// File: test/tb.sv
// Testbench for the sleep-aware watchdog timer
`timescale 1ns/1ps
module tb
  import wdtsm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] mode = 2'b11;
  logic clear_cmd = 1'b0;
  logic sleep_cmd = 1'b0;
  logic wake_cmd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic clr_i, sl_en, sl_ex, asleep;
  logic wdt_reset_req, wake_req, timeout_flag_n, powerdown_flag_n, watchdog_reset_flag, irq;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  wdtsm_core_model core_u (.clk_sys(clk_sys), .reset(reset), .clear_cmd(clear_cmd),
    .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd), .wake_req(wake_req),
    .watchdog_clear_instr(clr_i), .sleep_enter(sl_en), .sleep_exit(sl_ex), .asleep_q(asleep));

  // Crystal and oscillator inputs tied: their holds cannot be seen without long waits
  wdtsm_top dut_u (.clk_sys(clk_sys), .reset(reset), .wdt_mode_config(mode),
    .watchdog_clear_instr(clr_i), .sleep_enter(sl_en), .sleep_exit(sl_ex),
    .osc_fail(1'b0), .osc_startup_timer(1'b0), .sys_clk_is_crystal(1'b0),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req), .wake_req(wake_req),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
    .watchdog_reset_flag(watchdog_reset_flag), .irq(irq));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask : chk

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : reg_read

  // Ceiling covers one time-out at the shortest period, the mode phases and margin
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    reg_read(ADDR_WATCHDOG_CONTROL, 8'h16, "ctrl reset");
    reg_read(ADDR_POWER_CONTROL, 8'h03, "power reset");
    reg_read(ADDR_IRQ_MASK, 8'h00, "mask reset");
    reg_read(4'h7, 8'h00, "unmapped");
    reg_write(ADDR_WATCHDOG_CONTROL, 8'hff);
    reg_read(ADDR_WATCHDOG_CONTROL, 8'h3f, "ctrl unused bits");
    reg_write(ADDR_WATCHDOG_CONTROL, 8'h00);
    reg_read(ADDR_WATCHDOG_CONTROL, 8'h00, "ctrl period 0");
    @(posedge clk_sys);
    sleep_cmd <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("pd_n in sleep", powerdown_flag_n, 1'b0);
    reg_read(ADDR_POWER_CONTROL, 8'h01, "power sleep");
    sleep_cmd <= 1'b0;
    wake_cmd <= 1'b1;
    clear_cmd <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wake_cmd <= 1'b0;
    clear_cmd <= 1'b0;
    reg_read(ADDR_POWER_CONTROL, 8'h03, "power after clear");
    reg_write(ADDR_IRQ_MASK, 8'h01);
    // A clear midway must restart the full period; the wait spans two ticks
    repeat (4000) @(posedge clk_sys);
    clear_cmd <= 1'b1;
    @(posedge clk_sys);
    clear_cmd <= 1'b0;
    n = 0;
    // Sample after the edge so the one-cycle request is seen while it stands
    while (wdt_reset_req !== 1'b1 && n < 33 * 1612 + 50)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("reset req", wdt_reset_req, 1'b1);
    chk("period floor", n >= 31 * 1612 + 2, 1'b1);
    chk("period ceil", n <= 32 * 1612 + 1, 1'b1);
    chk("watchdog_reset_flag flag", watchdog_reset_flag, 1'b1);
    @(posedge clk_sys);
    #1;
    chk("req pulse", wdt_reset_req, 1'b0);
    chk("irq", irq, 1'b1);
    reg_read(ADDR_POWER_CONTROL, 8'h06, "power timeout");
    reg_read(ADDR_IRQ_STATUS, 8'h01, "status");
    reg_write(ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq masked", irq, 1'b0);
    reg_write(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq unmasked", irq, 1'b1);
    reg_write(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("irq cleared", irq, 1'b0);
    reg_write(ADDR_POWER_CONTROL, 8'h04);
    reg_read(ADDR_POWER_CONTROL, 8'h02, "watchdog_reset_flag cleared");
    // Mid-run reset into the awake-only mode
    @(posedge clk_sys);
    reset <= 1'b1;
    mode <= 2'b10;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    reg_read(ADDR_WATCHDOG_CONTROL, 8'h16, "ctrl after reset");
    reg_read(ADDR_POWER_CONTROL, 8'h03, "power after reset");
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("awake mode counts", dut_u.cnt_q != '0, 1'b1);
    sleep_cmd <= 1'b1;
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("awake mode held in sleep", dut_u.cnt_q, 32'h0);
    sleep_cmd <= 1'b0;
    wake_cmd <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wake_cmd <= 1'b0;
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("awake mode after wake", dut_u.cnt_q != '0, 1'b1);
    // Software mode follows the enable bit, also across sleep
    @(posedge clk_sys);
    reset <= 1'b1;
    mode <= 2'b01;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("sw mode off", dut_u.cnt_q, 32'h0);
    reg_write(ADDR_WATCHDOG_CONTROL, 8'h01);
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("sw mode on", dut_u.cnt_q != '0, 1'b1);
    sleep_cmd <= 1'b1;
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("sw mode in sleep", dut_u.cnt_q != '0, 1'b1);
    // Off mode ignores the enable bit
    @(posedge clk_sys);
    reset <= 1'b1;
    sleep_cmd <= 1'b0;
    mode <= 2'b00;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    reg_write(ADDR_WATCHDOG_CONTROL, 8'h01);
    repeat (2 * 1612) @(posedge clk_sys);
    #1;
    chk("off mode", dut_u.cnt_q, 32'h0);
    end_of_test();
  end
endmodule : tb
